//--- rtl/dii_pkg.sv
// Package for the digital-input interrupt block: offsets, fields, resets, timing
package dii_pkg;
  // Register offsets, byte addresses on the board register port
  localparam logic [7:0] DII_OFS_STATUS     = 8'h81;
  localparam logic [7:0] DII_OFS_VECT_BASE  = 8'hA1;
  localparam logic [7:0] DII_OFS_VECT_LAST  = 8'hAF;
  localparam logic [7:0] DII_OFS_PENDING    = 8'hC1;
  localparam logic [7:0] DII_OFS_ENABLE     = 8'hC3;
  localparam logic [7:0] DII_OFS_LEVEL_SEL  = 8'hC5;
  localparam logic [7:0] DII_OFS_TRIG_TYPE  = 8'hC7;
  localparam logic [7:0] DII_OFS_PAT_MASK   = 8'hC9;
  localparam logic [7:0] DII_OFS_IN_LO      = 8'hCA;
  localparam logic [7:0] DII_OFS_IN_HI      = 8'hCB;
  localparam logic [7:0] DII_OFS_OUT_LO     = 8'hCC;
  localparam logic [7:0] DII_OFS_OUT_HI     = 8'hCD;

  // Board status register fields
  localparam int DII_BIT_RED      = 0;
  localparam int DII_BIT_GREEN    = 1;
  localparam int DII_BIT_PENDING  = 2;
  localparam int DII_BIT_GIE      = 3;
  localparam int DII_BIT_SWRST    = 4;

  // Reset values
  localparam logic [7:0]  DII_RST_BYTE   = 8'h00;
  localparam logic [15:0] DII_RST_OUTPUT = 16'h0000;

  // Sizes
  localparam int DII_IRQ_CH  = 8;
  localparam int DII_IN_CH   = 16;
  localparam int DII_PAT_CH  = 7;

  // Interrupt-logic recognition delay, in ns, and its cycle count at 250 MHz
  localparam int DII_CLK_NS       = 4;
  localparam int DII_RECOG_MIN_NS = 1000;
  localparam int DII_RECOG_CYC    = (DII_RECOG_MIN_NS + DII_CLK_NS - 1) / DII_CLK_NS;

  // Register port request carried as one bundle
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dii_req_t;

  // Interrupt acknowledge answer
  typedef enum logic [1:0] {
    DII_IRQ_IDLE,
    DII_IRQ_REQ,
    DII_IRQ_ACKED
  } dii_irq_state_t;
endpackage

//--- rtl/dii_core.sv
// Digital-input interrupt generator with input, output and status registers
//
// Behaviour
// - Level-select bit 0 low, 1 high arms
// - Level select ignored in transition mode, except in the pattern match
// - Level-select bits reset to zero
// - Trigger type: 0 level, 1 any transition
// - Trigger-type bits reset to zero
// - Disabled channels never become pending, except seven on a pattern match
// - Pattern-mask bit includes channel in pattern
// - Pattern fires when all included match, global enabled
// - Pattern match sets channel seven pending
// - Pattern-mask bits reset to zero
// - Input register reads current sixteen levels
// - Output register drives relays, reads back
// - Output bits reset to zero
// - Health bits drive green, red, system fail
// - Request held until pending cleared by one
// - Only inputs zero to seven interrupt
// - Per-channel vector returned on acknowledge
// - Channel seven served first, zero last
// - One pending flag per channel, no queue
// - Recognition delayed after debounced input
// - Pending is condition AND enable, or pattern on seven; write-one clears
// - Enable zero blocks channel, not a pattern match on seven; reset clears
// - Global enable gates bus request, resets zero
`timescale 1ns/1ns
module dii_core
  import dii_pkg::*;
#(
  parameter int RECOG_CYC = DII_RECOG_CYC
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Register port
  input  wire dii_req_t          req_i,
  output logic [7:0]             rdata_o,
  output logic                   rvalid_o,
  // Interrupt acknowledge
  input  wire logic              iack_i,
  output logic                   irq_o,
  output logic [7:0]             vector_o,
  output logic                   vector_valid_o,
  // Field pins
  input  wire logic [15:0]       inputs_i,
  output logic [15:0]            solid_state_relay_switch_o,
  output logic                   green_led_o,
  output logic                   red_led_o,
  output logic                   sysfail_b_o
);

  localparam int CW = $clog2(RECOG_CYC + 1);

  logic [7:0]              level_sel_q;
  logic [7:0]              trig_type_q;
  logic [7:0]              pat_mask_q;
  logic [7:0]              enable_q;
  logic [7:0]              pending_q;
  logic [7:0]              pending_d;
  logic [15:0]             output_q;
  logic                    gie_q;
  logic                    green_q;
  logic                    red_q;
  logic [7:0]              vect_q [DII_IRQ_CH];
  logic [7:0]              lvl_q;
  logic [7:0]              prev_q;
  logic                    prev_ok_q;
  logic [CW-1:0]           dly_q [DII_IRQ_CH];
  logic [7:0]              recog;
  logic [7:0]              rdata_q;
  logic                    rvalid_q;
  logic [7:0]              vector_q;
  logic                    vector_valid_q;
  logic [2:0]              served_q;
  dii_irq_state_t          irq_st_q;

  // Decode
  wire          wr         = req_i.wr;
  wire          rd         = req_i.rd;
  wire [7:0]    a          = req_i.addr;
  wire [7:0]    wd         = req_i.wdata;
  wire          swrst      = wr && (a == DII_OFS_STATUS) && wd[DII_BIT_SWRST];
  wire          wr_status  = wr && (a == DII_OFS_STATUS);
  wire          wr_pend    = wr && (a == DII_OFS_PENDING);
  wire          wr_en      = wr && (a == DII_OFS_ENABLE);
  wire          wr_lvl     = wr && (a == DII_OFS_LEVEL_SEL);
  wire          wr_trig    = wr && (a == DII_OFS_TRIG_TYPE);
  wire          wr_pat     = wr && (a == DII_OFS_PAT_MASK);
  wire          wr_out_lo  = wr && (a == DII_OFS_OUT_LO);
  wire          wr_out_hi  = wr && (a == DII_OFS_OUT_HI);
  wire          in_vect    = (a >= DII_OFS_VECT_BASE) && (a <= DII_OFS_VECT_LAST) && a[0];
  wire [2:0]    vect_idx   = a[3:1];

  // Highest set bit of an eight-bit mask
  function automatic logic [2:0] top_bit(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Delayed recognition of the debounced interrupt-capable inputs; the counter restarts
  // whenever the pin agrees with the recognised level, so a shorter glitch is dropped
  genvar g;
  generate
    for (g = 0; g < DII_IRQ_CH; g++) begin : g_recog
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dly_q[g] <= '0;
        end else if (inputs_i[g] == lvl_q[g]) begin
          dly_q[g] <= '0;
        end else begin
          dly_q[g] <= (dly_q[g] == CW'(RECOG_CYC - 1)) ? '0 : dly_q[g] + CW'(1);
        end
      end
      assign recog[g] = (inputs_i[g] != lvl_q[g]) && (dly_q[g] == CW'(RECOG_CYC - 1));
    end
  endgenerate

  // Recognised levels, seeded from the pins in the first cycle after reset so that
  // an input already high at reset is never taken for a transition later on
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lvl_q <= DII_RST_BYTE;
    end else if (!prev_ok_q) begin
      lvl_q <= inputs_i[7:0];
    end else begin
      lvl_q <= lvl_q ^ recog;
    end
  end

  // Previous levels load from the current pins in the first cycle after reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q    <= DII_RST_BYTE;
      prev_ok_q <= 1'b0;
    end else if (!prev_ok_q) begin
      prev_q    <= inputs_i[7:0];
      prev_ok_q <= 1'b1;
    end else begin
      prev_q    <= lvl_q;
    end
  end

  // Channel conditions
  wire [7:0] level_hit = ~(lvl_q ^ level_sel_q);
  wire [7:0] edge_hit  = prev_ok_q ? (lvl_q ^ prev_q) : 8'h00;
  wire [7:0] cond      = (trig_type_q & edge_hit) | (~trig_type_q & level_hit);
  wire       pat_hit   = (pat_mask_q != 8'h00)
                         && ((level_hit & pat_mask_q) == pat_mask_q)
                         && gie_q;
  wire [7:0] set_bits  = (cond & enable_q)
                         | {pat_hit, 7'h00};
  wire [7:0] clr_bits  = wr_pend ? wd : 8'h00;

  // Set wins over a clear in the same cycle; single flag, no queue
  assign pending_d = (pending_q & ~clr_bits) | set_bits;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_sel_q <= DII_RST_BYTE;
      trig_type_q <= DII_RST_BYTE;
      pat_mask_q  <= DII_RST_BYTE;
      enable_q    <= DII_RST_BYTE;
      pending_q   <= DII_RST_BYTE;
      output_q    <= DII_RST_OUTPUT;
      gie_q       <= 1'b0;
      green_q     <= 1'b0;
      red_q       <= 1'b0;
    end else if (swrst) begin
      // Software reset clears configuration and pending state; vectors are kept
      level_sel_q <= DII_RST_BYTE;
      trig_type_q <= DII_RST_BYTE;
      pat_mask_q  <= DII_RST_BYTE;
      enable_q    <= DII_RST_BYTE;
      pending_q   <= DII_RST_BYTE;
      output_q    <= DII_RST_OUTPUT;
      gie_q       <= 1'b0;
      green_q     <= 1'b0;
      red_q       <= 1'b0;
    end else begin
      if (wr_lvl) begin
        level_sel_q <= wd;
      end
      if (wr_trig) begin
        trig_type_q <= wd;
      end
      if (wr_pat) begin
        pat_mask_q <= wd;
      end
      if (wr_en) begin
        enable_q <= wd;
      end
      if (wr_status) begin
        gie_q   <= wd[DII_BIT_GIE];
        green_q <= wd[DII_BIT_GREEN];
        red_q   <= wd[DII_BIT_RED];
      end
      if (wr_out_lo) begin
        output_q[7:0] <= wd;
      end
      if (wr_out_hi) begin
        output_q[15:8] <= wd;
      end
      pending_q <= pending_d;
    end
  end

  // Vector store, contents undefined until written; reset to zero here
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DII_IRQ_CH; i++) begin
        vect_q[i] <= DII_RST_BYTE;
      end
    end else if (wr && in_vect) begin
      vect_q[vect_idx] <= wd;
    end
  end

  // Read data
  wire [7:0] status_rd = {3'h0, 1'b0, gie_q, (pending_q != 8'h00), green_q, red_q};
  // Unmapped addresses read as zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (a == DII_OFS_STATUS) begin
      rd_mux = status_rd;
    end else if (in_vect) begin
      rd_mux = vect_q[vect_idx];
    end else if (a == DII_OFS_PENDING) begin
      rd_mux = pending_q;
    end else if (a == DII_OFS_ENABLE) begin
      rd_mux = enable_q;
    end else if (a == DII_OFS_LEVEL_SEL) begin
      rd_mux = level_sel_q;
    end else if (a == DII_OFS_TRIG_TYPE) begin
      rd_mux = trig_type_q;
    end else if (a == DII_OFS_PAT_MASK) begin
      rd_mux = pat_mask_q;
    end else if (a == DII_OFS_IN_LO) begin
      rd_mux = inputs_i[7:0];
    end else if (a == DII_OFS_IN_HI) begin
      rd_mux = inputs_i[15:8];
    end else if (a == DII_OFS_OUT_LO) begin
      rd_mux = output_q[7:0];
    end else if (a == DII_OFS_OUT_HI) begin
      rd_mux = output_q[15:8];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q  <= DII_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rd ? rd_mux : rdata_q;
      rvalid_q <= rd;
    end
  end

  // Interrupter: only channels 0-7 feed the request, highest first
  wire       any_pend = (pending_q != 8'h00);
  wire [2:0] top_ch   = top_bit(pending_q);
  // A request is offered only while something is pending and the global enable is on
  wire       req_ok   = any_pend && gie_q;
  // A persistent level condition keeps its pending bit set, so service of that
  // channel, and the request with it, lasts until the condition ends and the bit is cleared by a write of one, or the global enable goes off
  wire       srv_done = !pending_q[served_q] || !gie_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_st_q       <= DII_IRQ_IDLE;
      vector_q       <= DII_RST_BYTE;
      vector_valid_q <= 1'b0;
      served_q       <= 3'h0;
    end else begin
      vector_valid_q <= 1'b0;
      case (irq_st_q)
        DII_IRQ_IDLE: begin
          if (req_ok) begin
            irq_st_q <= DII_IRQ_REQ;
          end
        end
        DII_IRQ_REQ: begin
          if (!req_ok) begin
            irq_st_q <= DII_IRQ_IDLE;
          end else if (iack_i) begin
            vector_q       <= vect_q[top_ch];
            vector_valid_q <= 1'b1;
            served_q       <= top_ch;
            irq_st_q       <= DII_IRQ_ACKED;
          end
        end
        DII_IRQ_ACKED: begin
          // Request stays up until the served channel is cleared or the global enable goes off
          if (srv_done) begin
            irq_st_q <= DII_IRQ_IDLE;
          end
        end
        default: begin
          irq_st_q <= DII_IRQ_IDLE;
        end
      endcase
    end
  end

  assign irq_o                      = (irq_st_q != DII_IRQ_IDLE);
  assign vector_o                   = vector_q;
  assign vector_valid_o             = vector_valid_q;
  assign rdata_o                    = rdata_q;
  assign rvalid_o                   = rvalid_q;
  assign solid_state_relay_switch_o = output_q;
  assign green_led_o                = green_q;
  assign red_led_o                  = ~red_q;
  assign sysfail_b_o                = red_q;

endmodule

//--- sim/dii_core_asserts.sv
// Concurrent checks on the register port, relays, indicators and interrupt handshake
`timescale 1ns/1ns
module dii_core_chk
  import dii_pkg::*;
#(
  parameter int RECOG_CYC = DII_RECOG_CYC
) (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  // Register port
  input wire dii_req_t    req_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        rvalid_o,
  // Interrupt handshake
  input wire logic        iack_i,
  input wire logic        irq_o,
  input wire logic        vector_valid_o,
  // Field pins
  input wire logic [15:0] solid_state_relay_switch_o,
  input wire logic        green_led_o,
  input wire logic        red_led_o,
  input wire logic        sysfail_b_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_red; req_i.wr && req_i.addr == DII_OFS_STATUS && !req_i.wdata[DII_BIT_SWRST]
    |=> sysfail_b_o == $past(req_i.wdata[DII_BIT_RED]) && red_led_o == !sysfail_b_o
        && green_led_o == $past(req_i.wdata[DII_BIT_GREEN]); endproperty
  a_red: assert property (p_red)
    else $error("indicators do not follow the status write");
  property p_stat; req_i.rd && req_i.addr == DII_OFS_STATUS
    |=> rdata_o[1:0] == {green_led_o, sysfail_b_o}; endproperty
  a_stat: assert property (p_stat)
    else $error("status read disagrees with indicators");
  property p_rd_out; req_i.rd && req_i.addr == DII_OFS_OUT_LO
    |=> rvalid_o && rdata_o == solid_state_relay_switch_o[7:0]; endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output read back wrong");
  property p_wr_out; req_i.wr && req_i.addr == DII_OFS_OUT_HI
    |=> solid_state_relay_switch_o[15:8] == $past(req_i.wdata); endproperty
  a_wr_out: assert property (p_wr_out)
    else $error("relay byte not taken from write");
  property p_hold; !req_i.wr |=> $stable(solid_state_relay_switch_o); endproperty
  a_hold: assert property (p_hold)
    else $error("relays moved without a write");
  property p_ack; iack_i && irq_o |=> vector_valid_o; endproperty
  a_ack: assert property (p_ack)
    else $error("no vector after acknowledge");
  property p_vv; vector_valid_o |-> $past(iack_i) && $past(irq_o); endproperty
  a_vv: assert property (p_vv)
    else $error("vector without acknowledge");
  property p_fall; $fell(irq_o) |-> $past(req_i.wr) || $past(req_i.wr, 2); endproperty
  a_fall: assert property (p_fall)
    else $error("request dropped without a register write");
endmodule
bind dii_core dii_core_chk #(.RECOG_CYC(RECOG_CYC)) dii_core_chk_inst (
  .clock_i, .rst_b_i, .req_i, .rdata_o, .rvalid_o, .iack_i, .irq_o, .vector_valid_o,
  .solid_state_relay_switch_o, .green_led_o, .red_led_o, .sysfail_b_o);

//--- sim/dii_host_model.sv
// Host interrupt handler: acknowledges each new request after wait_i cycles
`timescale 1ns/1ns
module dii_host_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // Interrupt handshake
  input  wire logic       irq_i,
  input  wire logic [3:0] wait_i,
  output logic            iack_o
);
  logic [3:0] cnt_q;
  logic       armed_q;
  always @(negedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      armed_q <= 1'b1;
      iack_o <= 1'b0;
    end else begin
      iack_o <= 1'b0;
      if (!irq_i) begin
        armed_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (armed_q && cnt_q == wait_i) begin
        iack_o <= 1'b1;
        armed_q <= 1'b0;
      end else if (armed_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

//--- sim/tb.sv
// Self-checking bench for the digital-input interrupt block
`timescale 1ns/1ns
module tb
  import dii_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  dii_req_t    req = '0;
  logic [15:0] in_q = 16'h0000;
  logic [15:0] relay;
  logic [7:0]  rdata, vec, vec_q;
  logic        rvalid, iack, irq, vv, green, red, sysf;
  logic [3:0]  hw = 4'h3;
  logic [7:0]  zr [8] = '{8'h81, 8'hC1, 8'hC3, 8'hC5, 8'hC7, 8'hC9, 8'hCC, 8'h50};
  int          mismatches = 0;
  int          cmp_count = 0;
  int          vcnt = 0;
  always #2 clk = ~clk;
  dii_core #(.RECOG_CYC(2)) dii_core_inst (.clock_i(clk), .rst_b_i(rst_b), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .iack_i(iack), .irq_o(irq), .vector_o(vec),
    .vector_valid_o(vv), .inputs_i(in_q), .solid_state_relay_switch_o(relay),
    .green_led_o(green), .red_led_o(red), .sysfail_b_o(sysf));
  dii_host_model dii_host_model_inst (.clock_i(clk), .rst_b_i(rst_b), .irq_i(irq),
    .wait_i(hw), .iack_o(iack));
  always @(posedge clk) begin
    if (vv === 1'b1) begin
      vec_q <= vec;
      vcnt <= vcnt + 1;
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    chk({7'h00, rvalid, rdata}, {8'h01, e}, "read");
  endtask
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_vec(input logic [7:0] e);
    int n;
    n = vcnt;
    for (int i = 0; i < 40 && vcnt == n; i++) idle(1);
    if (vcnt == n) begin
      mismatches++;
      $display("[FAIL] %0t no acknowledge", $time);
      end_sim();
    end else begin
      chk({8'h00, vec_q}, {8'h00, e}, "vector");
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    chk({13'h0000, green, red, sysf}, 16'h0002, "indicators");
    foreach (zr[i]) rd(zr[i], 8'h00);
    wr(8'hCC, 8'hA5);
    wr(8'hCD, 8'h3C);
    rd(8'hCC, 8'hA5);
    rd(8'hCD, 8'h3C);
    chk(relay, 16'h3CA5, "relays");
    in_q = 16'hBE00;
    rd(8'hCA, 8'h00);
    rd(8'hCB, 8'hBE);
    for (int v = 0; v < 4; v++) begin
      wr(8'h81, 8'(v));
      rd(8'h81, 8'(v));
      chk({13'h0000, green, red, sysf}, {13'h0000, v[1], !v[0], v[0]}, "indicators");
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'(8'hA1 + 2 * c), 8'(8'h10 + c));
    end
    wr(8'hC3, 8'h22);
    idle(6);
    rd(8'hC1, 8'h22);
    chk({15'h0000, irq}, 16'h0000, "request");
    wr(8'h81, 8'h0B);
    wait_vec(8'h15);
    wr(8'hC1, 8'h20);
    idle(3);
    rd(8'hC1, 8'h22);
    hw <= 4'h0;
    wr(8'hC5, 8'hFF);
    wr(8'hC1, 8'h20);
    wait_vec(8'h11);
    wr(8'hC1, 8'h02);
    idle(3);
    rd(8'hC1, 8'h00);
    chk({15'h0000, irq}, 16'h0000, "request");
    wr(8'hC3, 8'h01);
    wr(8'hC7, 8'h01);
    wr(8'hC5, 8'h00);
    idle(6);
    rd(8'hC1, 8'h00);
    in_q[0] = 1'b1;
    wait_vec(8'h10);
    wr(8'hC1, 8'h01);
    idle(4);
    rd(8'hC1, 8'h00);
    wr(8'hC3, 8'h00);
    in_q[0] = 1'b0;
    wr(8'hC7, 8'h00);
    wr(8'hC5, 8'h07);
    idle(4);
    wr(8'hC9, 8'h06);
    in_q[1] = 1'b1;
    idle(6);
    rd(8'hC1, 8'h00);
    in_q[2] = 1'b1;
    wait_vec(8'h17);
    rd(8'hC1, 8'h80);
    wr(8'h81, 8'h1B);
    rd(8'hC9, 8'h00);
    rd(8'hCC, 8'h00);
    rd(8'hC1, 8'h00);
    rd(8'h81, 8'h00);
    chk(relay, 16'h0000, "relays");
    chk({13'h0000, green, red, sysf}, 16'h0002, "indicators");
    rd(8'hA1, 8'h10);
    rd(8'hAF, 8'h17);
    idle(2);
    chk({15'h0000, irq}, 16'h0000, "request");
    end_sim();
  end
endmodule
